// *** src/otf_regs.sv ***
// Offset trim and offset filter register bank, AXI4-Lite slave.
// Assumes the calibration engine supplies its flags and factory trims.
//
// Contract
// - Hold 12-bit trim for input A
// - Hold 12-bit trim for input B
// - Trim bits 15..12 read-write, reset zero
// - Trims load factory values at reset
// - Filter control low reset zero, spare bits
// - Keep-DC set removes only bank mismatch
// - Keep-DC clear removes all DC
// - Keep-DC only matters with filter enabled
// - Filter control high resets to 0x33
// - Upper nibble selects IIR bandwidth 1..5
`timescale 1ns/1ns
module otf_regs
  import otf_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Factory trims
  input wire logic [otf_pkg::OTF_TRIM_W-1:0] FACTORY_TRIM_INPUT_A,
  input wire logic [otf_pkg::OTF_TRIM_W-1:0] FACTORY_TRIM_INPUT_B,
  // Calibration engine flags, asynchronous
  input wire logic FG_CAL_BUSY,
  input wire logic FOREGROUND_CAL_DONE,
  input wire logic BACKGROUND_CAL_PAUSED,
  // Trim, filter and calibration-enable settings to datapath
  output logic [otf_pkg::OTF_TRIM_W-1:0] TRIM_INPUT_A,
  output logic [otf_pkg::OTF_TRIM_W-1:0] TRIM_INPUT_B,
  output logic FILTER_ACTIVE,
  output logic FILTER_KEEP_NEAR_DC,
  output logic [3:0] FILTER_BANDWIDTH_SELECT,
  output logic FILTER_BW_VALID,
  output logic BACKGROUND_CAL_ENABLE,
  output logic BACKGROUND_OFFSET_CAL_ENABLE,
  output logic OFFSET_CAL_ENABLE,
  // AXI4-Lite write address
  input wire logic [otf_pkg::OTF_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [otf_pkg::OTF_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import otf_pkg::*;

  // ==========================================================
  // Flag synchronisers
  logic [2:0] flags_s;
  logic fg_busy_s;
  logic foreground_cal_done_s;
  logic paused_s;

  otf_sync2 #(.WIDTH(3)) u_sync (
    .clk(CLOCK),
    .rst_n(RSTN),
    .async_in({BACKGROUND_CAL_PAUSED, FOREGROUND_CAL_DONE, FG_CAL_BUSY}),
    .sync_out(flags_s)
  );
  assign fg_busy_s = flags_s[0];
  assign foreground_cal_done_s = flags_s[1];
  assign paused_s = flags_s[2];

  // ==========================================================
  // Register state
  logic [15:0] trim_a_q, trim_a_d;
  logic [15:0] trim_b_q, trim_b_d;
  logic [7:0] filt_lo_q, filt_lo_d;
  logic [7:0] filt_hi_q, filt_hi_d;
  logic [OTF_CTL_W-1:0] ctl_q, ctl_d;
  logic loaded_q, loaded_d;
  logic wr_blocked;
  logic rd_unsafe;
  logic [OTF_ST_W-1:0] status;

  // Write guard reported to software; the bank itself still accepts writes
  assign wr_blocked = fg_busy_s | (ctl_q[OTF_CTL_BG] & ctl_q[OTF_CTL_BGOS]);
  assign rd_unsafe = (ctl_q[OTF_CTL_OS] & ~ctl_q[OTF_CTL_BGOS] & ~foreground_cal_done_s)
    | (ctl_q[OTF_CTL_BG] & ctl_q[OTF_CTL_BGOS] & ~paused_s);

  always_comb
  begin
    status = '0;
    status[OTF_ST_FG_BUSY] = fg_busy_s;
    status[OTF_ST_FG_COMPLETE] = foreground_cal_done_s;
    status[OTF_ST_PAUSED] = paused_s;
    status[OTF_ST_WR_BLOCKED] = wr_blocked;
    status[OTF_ST_RD_UNSAFE] = rd_unsafe;
  end

  // ==========================================================
  // Write channel
  otf_wstate_t wst_q, wst_d;
  logic [OTF_ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic [OTF_ADDR_W-3:0] widx;

  assign widx = waddr_q[OTF_ADDR_W-1:2];

  // Merge byte lanes so a partial write keeps the untouched bytes
  function automatic logic [15:0] otf_merge16(logic [15:0] old, logic [31:0] d,
                                              logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0])
      r[7:0] = d[7:0];
    if (s[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  always_comb
  begin
    wst_d = wst_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    trim_a_d = trim_a_q;
    trim_b_d = trim_b_q;
    filt_lo_d = filt_lo_q;
    filt_hi_d = filt_hi_q;
    ctl_d = ctl_q;
    loaded_d = 1'b1;
    if (!loaded_q)
    begin
      trim_a_d = {OTF_RSVD_RESET, FACTORY_TRIM_INPUT_A};
      trim_b_d = {OTF_RSVD_RESET, FACTORY_TRIM_INPUT_B};
    end
    case (wst_q)
      OTF_W_IDLE:
      begin
        if (AWVALID && awready_q)
        begin
          waddr_d = AWADDR;
          aw_have_d = 1'b1;
          awready_d = 1'b0;
        end
        if (WVALID && wready_q)
        begin
          wdata_d = WDATA;
          wstrb_d = WSTRB;
          w_have_d = 1'b1;
          wready_d = 1'b0;
        end
        if ((aw_have_q || (AWVALID && awready_q)) && (w_have_q || (WVALID && wready_q)))
          wst_d = OTF_W_GOT;
      end
      OTF_W_GOT:
      begin
        bresp_d = OTF_RESP_OKAY;
        if (widx == OTF_IDX_TRIM_B_IN_A)
          trim_a_d = otf_merge16(trim_a_q, wdata_q, wstrb_q);
        else if (widx == OTF_IDX_TRIM_B_IN_B)
          trim_b_d = otf_merge16(trim_b_q, wdata_q, wstrb_q);
        else if (widx == OTF_IDX_FILT_LO)
        begin
          if (wstrb_q[0])
            filt_lo_d = wdata_q[7:0];
        end
        else if (widx == OTF_IDX_FILT_HI)
        begin
          if (wstrb_q[0])
            filt_hi_d = wdata_q[7:0];
        end
        else if (widx == OTF_IDX_CAL_CTRL)
        begin
          if (wstrb_q[0])
            ctl_d = wdata_q[OTF_CTL_W-1:0];
        end
        else if (widx == OTF_IDX_CAL_STAT)
          bresp_d = OTF_RESP_OKAY;
        else
          bresp_d = OTF_RESP_SLVERR;
        bvalid_d = 1'b1;
        wst_d = OTF_W_RESP;
      end
      OTF_W_RESP:
      begin
        if (BREADY)
        begin
          bvalid_d = 1'b0;
          aw_have_d = 1'b0;
          w_have_d = 1'b0;
          awready_d = 1'b1;
          wready_d = 1'b1;
          wst_d = OTF_W_IDLE;
        end
      end
      default:
        wst_d = OTF_W_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      wst_q <= OTF_W_IDLE;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= OTF_RESP_OKAY;
      trim_a_q <= '0;
      trim_b_q <= '0;
      filt_lo_q <= OTF_FILT_LO_RESET;
      filt_hi_q <= OTF_FILT_HI_RESET;
      ctl_q <= '0;
      loaded_q <= 1'b0;
    end
    else
    begin
      wst_q <= wst_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      trim_a_q <= trim_a_d;
      trim_b_q <= trim_b_d;
      filt_lo_q <= filt_lo_d;
      filt_hi_q <= filt_hi_d;
      ctl_q <= ctl_d;
      loaded_q <= loaded_d;
    end
  end

  // ==========================================================
  // Read channel
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [OTF_ADDR_W-3:0] ridx;

  assign ridx = ARADDR[OTF_ADDR_W-1:2];

  always_comb
  begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q)
    begin
      if (RREADY)
      begin
        rvalid_d = 1'b0;
        arready_d = 1'b1;
      end
    end
    else if (ARVALID && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = OTF_RESP_OKAY;
      rdata_d = '0;
      if (ridx == OTF_IDX_TRIM_B_IN_A)
        rdata_d[15:0] = trim_a_q;
      else if (ridx == OTF_IDX_TRIM_B_IN_B)
        rdata_d[15:0] = trim_b_q;
      else if (ridx == OTF_IDX_FILT_LO)
        rdata_d[7:0] = filt_lo_q;
      else if (ridx == OTF_IDX_FILT_HI)
        rdata_d[7:0] = filt_hi_q;
      else if (ridx == OTF_IDX_CAL_CTRL)
        rdata_d[OTF_CTL_W-1:0] = ctl_q;
      else if (ridx == OTF_IDX_CAL_STAT)
        rdata_d[OTF_ST_W-1:0] = status;
      else
        rresp_d = OTF_RESP_SLVERR;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= OTF_RESP_OKAY;
    end
    else
    begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ==========================================================
  // Datapath settings, all registered
  logic [15:0] set_d, set_q;
  logic [3:0] bw;

  assign bw = filt_hi_q[OTF_BW_LSB +: 4];

  always_comb
  begin
    set_d = '0;
    set_d[15:4] = '0;
    set_d[0] = ctl_q[OTF_CTL_FILT];
    // Keep-DC is masked off when filtering is not enabled
    set_d[1] = ctl_q[OTF_CTL_FILT] & filt_lo_q[OTF_DC_KEEP_BIT];
    set_d[2] = (bw >= OTF_BW_MIN) && (bw <= OTF_BW_MAX);
    set_d[6:3] = bw;
    set_d[7] = ctl_q[OTF_CTL_BG];
    set_d[8] = ctl_q[OTF_CTL_BGOS];
    set_d[9] = ctl_q[OTF_CTL_OS];
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
      set_q <= '0;
    else
      set_q <= set_d;
  end

  assign TRIM_INPUT_A = trim_a_q[OTF_TRIM_W-1:0];
  assign TRIM_INPUT_B = trim_b_q[OTF_TRIM_W-1:0];
  assign FILTER_ACTIVE = set_q[0];
  assign FILTER_KEEP_NEAR_DC = set_q[1];
  assign FILTER_BW_VALID = set_q[2];
  assign FILTER_BANDWIDTH_SELECT = set_q[6:3];
  assign BACKGROUND_CAL_ENABLE = set_q[7];
  assign BACKGROUND_OFFSET_CAL_ENABLE = set_q[8];
  assign OFFSET_CAL_ENABLE = set_q[9];
  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
endmodule

// *** common/otf_pkg.sv ***
// Package for the offset trim and offset filter register bank.
// Assumes a 32-bit AXI4-Lite register port, one word per register.
package otf_pkg;
  // ==========================================================
  // Register indices; the byte address is four times the index
  localparam logic [11:0] OTF_IDX_TRIM_B_IN_A = 12'h092;
  localparam logic [11:0] OTF_IDX_TRIM_B_IN_B = 12'h094;
  localparam logic [11:0] OTF_IDX_FILT_LO = 12'h097;
  localparam logic [11:0] OTF_IDX_FILT_HI = 12'h098;
  localparam logic [11:0] OTF_IDX_CAL_CTRL = 12'h0A0;
  localparam logic [11:0] OTF_IDX_CAL_STAT = 12'h0A1;
  localparam int OTF_ADDR_W = 14;
  // ==========================================================
  // Fields and reset values
  localparam int OTF_TRIM_W = 12;
  localparam int OTF_RSVD_W = 4;
  localparam logic [3:0] OTF_RSVD_RESET = 4'h0;
  localparam logic [7:0] OTF_FILT_LO_RESET = 8'h00;
  localparam logic [7:0] OTF_FILT_HI_RESET = 8'h33;
  localparam int OTF_DC_KEEP_BIT = 0;
  localparam int OTF_BW_LSB = 4;
  localparam logic [3:0] OTF_BW_MIN = 4'h1;
  localparam logic [3:0] OTF_BW_MAX = 4'h5;
  // Control register bits
  localparam int OTF_CTL_BG = 0;
  localparam int OTF_CTL_BGOS = 1;
  localparam int OTF_CTL_OS = 2;
  localparam int OTF_CTL_FILT = 3;
  localparam int OTF_CTL_W = 4;
  // Status register bits
  localparam int OTF_ST_FG_BUSY = 0;
  localparam int OTF_ST_FG_COMPLETE = 1;
  localparam int OTF_ST_PAUSED = 2;
  localparam int OTF_ST_WR_BLOCKED = 3;
  localparam int OTF_ST_RD_UNSAFE = 4;
  localparam int OTF_ST_W = 5;
  // AXI responses
  localparam logic [1:0] OTF_RESP_OKAY = 2'h0;
  localparam logic [1:0] OTF_RESP_SLVERR = 2'h2;
  // Write slave states
  typedef enum logic [2:0] {
    OTF_W_IDLE = 3'b001,
    OTF_W_GOT = 3'b010,
    OTF_W_RESP = 3'b100
  } otf_wstate_t;
endpackage

// *** src/otf_sync2.sv ***
// Two-flop synchroniser for a bus of calibration-engine flags.
// Assumes the flags come from another clock domain and are levels.
`timescale 1ns/1ns
module otf_sync2 #(
  parameter int WIDTH = 3
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Flags
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// *** tb/otf_regs_monitor.sv ***
// Bus and filter-output checks for the offset trim register bank.
// Assumes binding to otf_regs; sees only its ports.
`timescale 1ns/1ns
module otf_regs_monitor
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  // Filter settings
  input wire logic FILTER_ACTIVE,
  input wire logic FILTER_KEEP_NEAR_DC,
  input wire logic [3:0] FILTER_BANDWIDTH_SELECT,
  input wire logic FILTER_BW_VALID
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  a_bresp_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  a_rdata_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  a_read_latency: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  a_write_latency: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
    else $error("write answer timing wrong");
  a_read_release: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read channel not released");
  a_write_refused: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted while busy");
  a_keep_dc_gated: assert property (FILTER_KEEP_NEAR_DC |-> FILTER_ACTIVE)
    else $error("keep-DC active without filter");
  a_bw_code_ok: assert property (FILTER_BW_VALID == (FILTER_BANDWIDTH_SELECT inside {[1:5]}))
    else $error("bandwidth valid flag wrong");
endmodule

bind otf_regs otf_regs_monitor u_mon (.*);

// *** tb/test_otf_regs.sv ***
// Self-checking bench for the offset trim and filter register bank.
// Assumes AXI4-Lite reads answer in one cycle, writes in two.
`timescale 1ns/1ns
module test_otf_regs;
  import otf_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [11:0] FA = 12'hA5C;
  localparam logic [11:0] FB = 12'h3C7;
  localparam logic [13:0] A_TA = {OTF_IDX_TRIM_B_IN_A, 2'h0};
  localparam logic [13:0] A_TB = {OTF_IDX_TRIM_B_IN_B, 2'h0};
  localparam logic [13:0] A_LO = {OTF_IDX_FILT_LO, 2'h0};
  localparam logic [13:0] A_HI = {OTF_IDX_FILT_HI, 2'h0};
  localparam logic [13:0] A_CT = {OTF_IDX_CAL_CTRL, 2'h0};
  localparam logic [13:0] A_ST = {OTF_IDX_CAL_STAT, 2'h0};
  logic CLOCK = 1'h0, RSTN = 1'h0, FG_CAL_BUSY = 1'h0, FOREGROUND_CAL_DONE = 1'h0;
  logic BACKGROUND_CAL_PAUSED = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic ARVALID = 1'h0, RREADY = 1'h0;
  logic [11:0] FACTORY_TRIM_INPUT_A = FA, FACTORY_TRIM_INPUT_B = FB;
  logic [11:0] TRIM_INPUT_A, TRIM_INPUT_B;
  logic [13:0] AWADDR = 14'h0, ARADDR = 14'h0;
  logic [31:0] WDATA = 32'h0, RDATA, rd_q;
  logic [3:0] WSTRB = 4'h0, FILTER_BANDWIDTH_SELECT;
  logic [1:0] BRESP, RRESP, rs;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FILTER_ACTIVE, FILTER_KEEP_NEAR_DC;
  logic FILTER_BW_VALID, BACKGROUND_CAL_ENABLE, BACKGROUND_OFFSET_CAL_ENABLE, OFFSET_CAL_ENABLE;
  int errors = 0, tests_run = 0, cycles = 0;

  otf_regs uut (.*);

  always #25 CLOCK = ~CLOCK;

  // ==========================================================
  // Tasks
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    bit b;
    b = 0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    while (!b)
    begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
      if (BVALID)
      begin
        b = 1;
        rs = BRESP;
        BREADY <= 1'h0;
      end
    end
  endtask

  task automatic rd(input logic [13:0] a);
    bit b;
    b = 0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    while (!b)
    begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'h0;
      if (RVALID)
      begin
        b = 1;
        rd_q = RDATA;
        rs = RRESP;
        RREADY <= 1'h0;
      end
    end
  endtask

  task automatic rchk(input string n, input logic [13:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, rd_q);
  endtask

  task automatic settle;
    repeat (3) @(posedge CLOCK);
  endtask

  // Hang guard, run needs about 240 cycles
  always @(posedge CLOCK)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (5) @(posedge CLOCK);
    RSTN <= 1'h1;
    rchk("trim_a", A_TA, {20'h0, FA});
    rchk("trim_b", A_TB, {20'h0, FB});
    rchk("filt_lo", A_LO, 32'h0);
    rchk("filt_hi", A_HI, 32'h33);
    chk("out_a", FA, TRIM_INPUT_A);
    $display("test reset values done");
    wr(A_TA, 32'hF123, 4'h3);
    chk("bresp", OTF_RESP_OKAY, rs);
    rchk("trim_a", A_TA, 32'hF123);
    chk("out_a", 32'h123, TRIM_INPUT_A);
    wr(A_TB, 32'h00AB, 4'h1);
    rchk("trim_b", A_TB, 32'h3AB);
    chk("out_b", 32'h3AB, TRIM_INPUT_B);
    $display("test trims done");
    wr(A_LO, 32'hFF, 4'h1);
    rchk("filt_lo", A_LO, 32'hFF);
    wr(A_CT, 32'h8, 4'h1);
    rchk("ctrl", A_CT, 32'h8);
    chk("active", 1, FILTER_ACTIVE);
    chk("keep_dc", 1, FILTER_KEEP_NEAR_DC);
    wr(A_LO, 32'hFE, 4'h1);
    rchk("filt_lo", A_LO, 32'hFE);
    chk("keep_dc", 0, FILTER_KEEP_NEAR_DC);
    wr(A_LO, 32'h1, 4'h1);
    wr(A_CT, 32'h0, 4'h1);
    rchk("ctrl", A_CT, 32'h0);
    chk("keep_dc", 0, FILTER_KEEP_NEAR_DC);
    for (int c = 0; c < 16; c++)
    begin
      wr(A_HI, {24'h0, c[3:0], 4'h3}, 4'h1);
      rchk("filt_hi", A_HI, {24'h0, c[3:0], 4'h3});
      chk("bw_sel", c, FILTER_BANDWIDTH_SELECT);
      chk("bw_ok", (c >= 1 && c <= 5), FILTER_BW_VALID);
    end
    $display("test filter done");
    FG_CAL_BUSY <= 1'h1;
    settle();
    rchk("status", A_ST, 32'h09);
    FG_CAL_BUSY <= 1'h0;
    wr(A_CT, 32'h3, 4'h1);
    rchk("status", A_ST, 32'h18);
    chk("cal_en", 32'h3, {OFFSET_CAL_ENABLE, BACKGROUND_OFFSET_CAL_ENABLE, BACKGROUND_CAL_ENABLE});
    BACKGROUND_CAL_PAUSED <= 1'h1;
    settle();
    rchk("status", A_ST, 32'h0C);
    rchk("trim_b", A_TB, 32'h3AB);
    wr(A_CT, 32'h4, 4'h1);
    BACKGROUND_CAL_PAUSED <= 1'h0;
    settle();
    rchk("status", A_ST, 32'h10);
    FOREGROUND_CAL_DONE <= 1'h1;
    settle();
    rchk("status", A_ST, 32'h02);
    rchk("trim_a", A_TA, 32'hF123);
    $display("test cal flags done");
    wr(14'h3FC, 32'h5, 4'hF);
    chk("bresp", OTF_RESP_SLVERR, rs);
    rchk("unmapped", 14'h3FC, 32'h0);
    chk("rresp", OTF_RESP_SLVERR, rs);
    wr(A_ST, 32'hFF, 4'h1);
    chk("bresp", OTF_RESP_OKAY, rs);
    @(posedge CLOCK);
    RSTN <= 1'h0;
    @(posedge CLOCK);
    RSTN <= 1'h1;
    rchk("filt_hi", A_HI, 32'h33);
    rchk("trim_a", A_TA, {20'h0, FA});
    $display("test errors and reset done");
    tally_and_finish();
  end
endmodule
